// ### verilog/lpm_consts.vh
/*
 Constants for the low-power mode controller: timing counts and clock rate.
 Assumes inclusion by bare name from the design files.
*/
`ifndef LPM_CONSTS_VH
`define LPM_CONSTS_VH
`define LPM_CLK_MHZ 125
`define LPM_REC_LONG 4096
`define LPM_REC_SHORT 32
`define LPM_REC_W 12
`endif

// ### verilog/lpm_sync.v
/*
 Two-flop synchroniser, one per bit, for asynchronous inputs.
 Assumes a single clock domain and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module lpm_sync #(
    parameter W = 1
) (
    input wire core_clk,
    input wire rstn,
    input wire [W-1:0] din,
    output wire [W-1:0] dout
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    always @(posedge core_clk)
    begin
        if (!rstn)
        begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
        end
        else
        begin
            s1_q <= din;
            s2_q <= s1_q;
        end
    end
    assign dout = s2_q;
endmodule

// ### verilog/lpm_ctrl.v
/*
 Wait/stop low-power mode controller: clock gating, peripheral mode controls,
 interrupt-mask side effects, wake qualification and stop recovery counting.
 Assumes CPU strobes and core inputs are synchronous to core_clk; wake
 requests from pins and the voltage monitor arrive asynchronously.
*/
`timescale 1ns/1ps
`include "lpm_consts.vh"
module lpm_ctrl #(
    parameter REC_LONG = `LPM_REC_LONG,
    parameter REC_SHORT = `LPM_REC_SHORT
) (
    input wire core_clk,
    input wire rstn,
    input wire wait_exec,
    input wire stop_exec,
    input wire stop_enable,
    input wire osc_in_stop_enable,
    input wire short_recovery_select,
    input wire pll_bus_select_in,
    input wire pll_power_on_in,
    input wire lvi_enable,
    input wire lvi_reset_enable,
    input wire pin_irq_mask,
    input wire keyboard_irq_mask,
    input wire pin_irq_req,
    input wire keyboard_irq_req,
    input wire lvi_trip,
    input wire break_req,
    input wire adc_irq_req,
    input wire sci_irq_req,
    input wire other_irq_req,
    input wire wait_break_clear,
    output reg cpu_clk_en,
    output reg bus_clk_en,
    output reg osc_enable,
    output reg pll_enable,
    output reg pll_bus_select_clr,
    output reg cgm_out_hold_low,
    output reg adc_run,
    output reg adc_abort,
    output reg brk_active,
    output reg wait_break_flag,
    output reg wdog_clk_en,
    output reg wdog_prescaler_clr,
    output reg sci_run,
    output reg lvi_active,
    output reg imask_clear,
    output reg imask_set,
    output reg lvi_reset_out,
    output reg in_wait,
    output reg in_stop,
    output reg recovering,
    output reg vector_fetch
);
    localparam [3:0] ST_RUN = 4'h1;
    localparam [3:0] ST_WAIT = 4'h2;
    localparam [3:0] ST_STOP = 4'h4;
    localparam [3:0] ST_REC = 4'h8;
    localparam [31:0] REC_L_FULL = REC_LONG - 1;
    localparam [31:0] REC_S_FULL = REC_SHORT - 1;
    // Counter holds only the low bits; both lengths must fit its width
    localparam [`LPM_REC_W-1:0] REC_L = REC_L_FULL[`LPM_REC_W-1:0];
    localparam [`LPM_REC_W-1:0] REC_S = REC_S_FULL[`LPM_REC_W-1:0];

    wire [3:0] async_s;
    wire pin_s;
    wire kbd_s;
    wire lvi_s;
    wire brk_s;
    reg [3:0] st_q;
    reg [3:0] st_d;
    reg [`LPM_REC_W-1:0] cnt_q;
    reg [`LPM_REC_W-1:0] cnt_d;
    reg pin_wake;
    reg kbd_wake;
    reg lvi_wake;
    reg wait_wake;
    reg stop_wake;

    // Decoded next state and next values of the registered outputs
    reg run_d;
    reg wait_d;
    reg stop_d;
    reg rec_d;
    reg run_now;
    reg low_now;
    reg stop_entry;
    reg lvi_exit;
    reg cpu_clk_en_d;
    reg bus_clk_en_d;
    reg osc_enable_d;
    reg pll_enable_d;
    reg pll_bus_select_clr_d;
    reg cgm_out_hold_low_d;
    reg adc_run_d;
    reg adc_abort_d;
    reg brk_active_d;
    reg wait_break_flag_d;
    reg wdog_clk_en_d;
    reg wdog_prescaler_clr_d;
    reg sci_run_d;
    reg lvi_active_d;
    reg imask_clear_d;
    reg imask_set_d;
    reg lvi_reset_out_d;
    reg vector_fetch_d;

    // Pins, break and the voltage monitor are not timed to core_clk
    lpm_sync #(.W(4)) u_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .din({break_req, lvi_trip, keyboard_irq_req, pin_irq_req}),
        .dout(async_s)
    );
    assign pin_s = async_s[0];
    assign kbd_s = async_s[1];
    assign lvi_s = async_s[2];
    assign brk_s = async_s[3];

    always @*
    begin
        pin_wake = pin_s & ~pin_irq_mask;
        kbd_wake = kbd_s & ~keyboard_irq_mask;
        lvi_wake = lvi_s & lvi_enable & lvi_reset_enable;
        wait_wake = pin_wake | kbd_wake | brk_s | adc_irq_req | sci_irq_req
            | other_irq_req;
        // Break wakes stop too; pins count only when unmasked
        stop_wake = pin_wake | kbd_wake | brk_s;
        st_d = st_q;
        cnt_d = cnt_q;
        case (st_q)
            // Wait has priority when both strobes arrive together
            ST_RUN:
            begin
                if (wait_exec)
                    st_d = ST_WAIT;
                else if (stop_exec && stop_enable)
                    st_d = ST_STOP;
            end
            ST_WAIT:
            begin
                if (wait_wake)
                    st_d = ST_RUN;
            end
            ST_STOP:
            begin
                if (stop_wake)
                begin
                    st_d = ST_REC;
                    cnt_d = short_recovery_select ? REC_S : REC_L;
                end
            end
            // Counter is loaded on the wake edge and counts down to zero
            ST_REC:
            begin
                if (cnt_q == {`LPM_REC_W{1'b0}})
                    st_d = ST_RUN;
                else
                    cnt_d = cnt_q - 1'b1;
            end
            default:
            begin
                st_d = ST_RUN;
            end
        endcase
        // Voltage-monitor reset overrides wait, stop or recovery (not run) and restarts execution
        if (lvi_wake && st_q != ST_RUN)
        begin
            st_d = ST_RUN;
            cnt_d = {`LPM_REC_W{1'b0}};
        end
    end

    // Next values of the registered outputs, decoded from the current and next state
    always @*
    begin
        // One-hot next state split into named bits
        run_d = st_d[0];
        wait_d = st_d[1];
        stop_d = st_d[2];
        rec_d = st_d[3];
        run_now = st_q[0];
        low_now = ~st_q[0];
        // Stop-entry pulses fire only on the RUN to STOP step
        stop_entry = run_now & stop_d;
        // Voltage-monitor exit is a reset-type wake
        lvi_exit = lvi_wake & low_now;
        cpu_clk_en_d = run_d;
        // Bus clock survives stop only with the oscillator kept alive
        bus_clk_en_d = run_d | wait_d | ((stop_d | rec_d) & osc_in_stop_enable);
        osc_enable_d = ~(stop_d & ~osc_in_stop_enable);
        // PLL follows software in wait so a user can drop it to save power
        pll_enable_d = ~(stop_d | rec_d) & (wait_d ? pll_power_on_in : 1'b1);
        cgm_out_hold_low_d = stop_d & ~osc_in_stop_enable;
        pll_bus_select_clr_d = stop_entry & pll_bus_select_in;
        adc_run_d = run_d | wait_d;
        adc_abort_d = stop_entry;
        brk_active_d = ~stop_d;
        // Watchdog loses its crystal feed in stop even with the oscillator kept alive
        wdog_clk_en_d = ~(stop_d | rec_d);
        wdog_prescaler_clr_d = stop_entry;
        // A frame caught by stop is lost; the serial block keeps its registers
        sci_run_d = ~(stop_d | rec_d);
        lvi_active_d = lvi_enable;
        // Mask side effects: clear on entry, set only on a reset-type exit
        imask_clear_d = run_now & (wait_d | stop_d);
        imask_set_d = lvi_exit;
        lvi_reset_out_d = lvi_exit;
        // Any exit to RUN starts the vector fetch, reset or interrupt alike
        vector_fetch_d = low_now & run_d;
        // Set wins over clear when both arrive together
        if (brk_s && (st_q[1] || st_q[2]))
            wait_break_flag_d = 1'b1;
        else if (wait_break_clear)
            wait_break_flag_d = 1'b0;
        else
            wait_break_flag_d = wait_break_flag;
    end

    always @(posedge core_clk)
    begin
        // All clocks run and all pulses are low out of reset
        if (!rstn)
        begin
            st_q <= ST_RUN;
            cnt_q <= {`LPM_REC_W{1'b0}};
            cpu_clk_en <= 1'b1;
            bus_clk_en <= 1'b1;
            osc_enable <= 1'b1;
            pll_enable <= 1'b1;
            pll_bus_select_clr <= 1'b0;
            cgm_out_hold_low <= 1'b0;
            adc_run <= 1'b1;
            adc_abort <= 1'b0;
            brk_active <= 1'b1;
            wait_break_flag <= 1'b0;
            wdog_clk_en <= 1'b1;
            wdog_prescaler_clr <= 1'b0;
            sci_run <= 1'b1;
            lvi_active <= 1'b0;
            imask_clear <= 1'b0;
            imask_set <= 1'b0;
            lvi_reset_out <= 1'b0;
            in_wait <= 1'b0;
            in_stop <= 1'b0;
            recovering <= 1'b0;
            vector_fetch <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            in_wait <= st_d[1];
            in_stop <= st_d[2];
            recovering <= st_d[3];
            cpu_clk_en <= cpu_clk_en_d;
            bus_clk_en <= bus_clk_en_d;
            osc_enable <= osc_enable_d;
            pll_enable <= pll_enable_d;
            cgm_out_hold_low <= cgm_out_hold_low_d;
            pll_bus_select_clr <= pll_bus_select_clr_d;
            adc_run <= adc_run_d;
            adc_abort <= adc_abort_d;
            brk_active <= brk_active_d;
            wdog_clk_en <= wdog_clk_en_d;
            wdog_prescaler_clr <= wdog_prescaler_clr_d;
            sci_run <= sci_run_d;
            lvi_active <= lvi_active_d;
            imask_clear <= imask_clear_d;
            imask_set <= imask_set_d;
            lvi_reset_out <= lvi_reset_out_d;
            vector_fetch <= vector_fetch_d;
            wait_break_flag <= wait_break_flag_d;
        end
    end
endmodule

// ### testbench/lpm_ctrl_chk.sv
/* Concurrent checks on the low-power controller ports.
   Assumes one core_clk domain, synchronous active-low rstn, 32-cycle short recovery. */
`timescale 1ns/1ps
module lpm_ctrl_chk (
    input wire core_clk, rstn, wait_exec, stop_exec, stop_enable, osc_in_stop_enable,
    input wire short_recovery_select, pll_bus_select_in, adc_irq_req, sci_irq_req, other_irq_req,
    input wire in_wait, in_stop, recovering, cpu_clk_en, bus_clk_en, imask_clear, vector_fetch,
    input wire adc_run, adc_abort, sci_run, brk_active, wdog_clk_en, wdog_prescaler_clr,
    input wire osc_enable, pll_enable, cgm_out_hold_low, pll_bus_select_clr
);
    wire run = !in_wait && !in_stop && !recovering;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_wait_entry: assert property (
        run && wait_exec |=> in_wait && !cpu_clk_en && bus_clk_en && imask_clear)
        else $error("wait entry wrong");
    a_stop_entry: assert property (
        run && stop_exec && stop_enable && !wait_exec |=> in_stop && !cpu_clk_en
        && imask_clear && bus_clk_en == osc_in_stop_enable) else $error("stop entry wrong");
    a_stop_refused: assert property (
        run && stop_exec && !stop_enable && !wait_exec |=> !in_stop)
        else $error("disabled stop taken");
    a_stop_pulses: assert property (
        $rose(in_stop) |-> adc_abort && wdog_prescaler_clr
        && pll_bus_select_clr == $past(pll_bus_select_in)) else $error("stop pulses wrong");
    a_stop_periph: assert property (
        in_stop |-> !adc_run && !sci_run && !brk_active && !wdog_clk_en)
        else $error("peripheral active in stop");
    a_wait_periph: assert property (
        in_wait |-> adc_run && sci_run && wdog_clk_en) else $error("peripheral idle in wait");
    a_stop_cgm: assert property (
        in_stop |-> !pll_enable && osc_enable == osc_in_stop_enable
        && cgm_out_hold_low == !osc_in_stop_enable) else $error("clock generator wrong in stop");
    a_cpu_held: assert property (
        recovering |-> !cpu_clk_en) else $error("cpu clock during recovery");
    a_rec_short: assert property (
        $rose(recovering) && short_recovery_select |-> ##31 recovering ##1 !recovering
        && cpu_clk_en && vector_fetch) else $error("short recovery length wrong");
    a_wait_wake: assert property (
        in_wait && (adc_irq_req || sci_irq_req || other_irq_req) |=> !in_wait && cpu_clk_en
        && vector_fetch) else $error("wait wake wrong");
endmodule
bind lpm_ctrl lpm_ctrl_chk u_chk (.*);

// ### testbench/lpm_wake_src.sv
/* Far-side wake source: a pin or break request that stays up until the vector fetch.
   Assumes fire is pulsed by the bench; the request edge is off the clock on purpose. */
`timescale 1ns/1ps
module lpm_wake_src (
    input wire fire,
    input wire vector_fetch,
    output reg req
);
    initial req = 1'b0;
    // Asynchronous edge exercises the design's synchroniser
    always @(posedge fire) #3 req = 1'b1;
    // Handler acknowledges the level source once it runs
    always @(posedge vector_fetch) req = 1'b0;
endmodule

// ### testbench/test_low_power_mode_control.sv
/* Self-checking bench for lpm_ctrl with shortened long recovery.
   Assumes lpm_wake_src models the pins and break source. */
`timescale 1ns/1ps
module test_low_power_mode_control;
    reg core_clk = 0, rstn = 0, wait_exec = 0, stop_exec = 0, stop_enable = 0;
    reg osc_in_stop_enable = 0, short_recovery_select = 0, pll_bus_select_in = 0;
    reg pll_power_on_in = 1, lvi_enable = 0, lvi_reset_enable = 0, pin_irq_mask = 1;
    reg keyboard_irq_mask = 1, lvi_trip = 0, adc_irq_req = 0, sci_irq_req = 0;
    reg other_irq_req = 0, wait_break_clear = 0, pin_go = 0, kbd_go = 0, brk_go = 0;
    wire pin_irq_req, keyboard_irq_req, break_req, cpu_clk_en, bus_clk_en, osc_enable;
    wire pll_enable, pll_bus_select_clr, cgm_out_hold_low, adc_run, adc_abort, brk_active;
    wire wait_break_flag, wdog_clk_en, wdog_prescaler_clr, sci_run, lvi_active, imask_clear;
    wire imask_set, lvi_reset_out, in_wait, in_stop, recovering, vector_fetch;
    integer errors = 0, tests_run = 0, n, i, r;
    always #4 core_clk = ~core_clk;
    lpm_ctrl #(.REC_LONG(40)) u_dut (.*);
    lpm_wake_src u_pin (.fire(pin_go), .vector_fetch(vector_fetch), .req(pin_irq_req));
    lpm_wake_src u_kbd (.fire(kbd_go), .vector_fetch(vector_fetch), .req(keyboard_irq_req));
    lpm_wake_src u_brk (.fire(brk_go), .vector_fetch(vector_fetch), .req(break_req));
    task tick(input integer k);
        repeat (k) @(negedge core_clk);
    endtask
    task cmp(input string nm, input exp, input got);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
        end
    endtask
    task cmpn(input string nm, input integer exp, input integer got);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %0d seen %0d", nm, exp, got);
        end
    endtask
    function integer rec_exp(input s);
        rec_exp = s ? 32 : 40;
    endfunction
    task end_of_test;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        #100000;
        errors++;
        end_of_test;
    end
    initial
    begin
        r = $urandom(32'hCD78);
        tick(2);
        rstn = 1;
        for (i = 0; i < 4; i++)
        begin
            pll_power_on_in = $urandom;
            wait_exec = 1;
            tick(1);
            wait_exec = 0;
            cmp("in_wait", 1, in_wait);
            cmp("bus_clk_en", 1, bus_clk_en);
            tick($urandom_range(1, 9));
            if (i == 3)
                brk_go = 1;
            else
                {adc_irq_req, sci_irq_req, other_irq_req} = 3'h4 >> i;
            n = 0;
            while (cpu_clk_en !== 1'b1 && n < 20)
            begin
                tick(1);
                n++;
            end
            {adc_irq_req, sci_irq_req, other_irq_req, brk_go} = 4'h0;
            cmp("wake", 1, cpu_clk_en);
        end
        cmp("wait_break_flag", 1, wait_break_flag);
        wait_break_clear = 1;
        tick(1);
        wait_break_clear = 0;
        tick(1);
        cmp("wait_break_flag", 0, wait_break_flag);
        stop_exec = 1;
        tick(1);
        stop_exec = 0;
        cmp("in_stop", 0, in_stop);
        stop_enable = 1;
        for (i = 0; i < 5; i++)
        begin
            short_recovery_select = i[0];
            osc_in_stop_enable = $urandom;
            pll_bus_select_in = $urandom;
            lvi_enable = (i == 4);
            lvi_reset_enable = (i == 4);
            stop_exec = 1;
            tick(1);
            stop_exec = 0;
            cmp("bus_clk_en", osc_in_stop_enable, bus_clk_en);
            pin_go = !i[1];
            kbd_go = i[1];
            tick(8);
            cmp("in_stop", 1, in_stop);
            pin_irq_mask = i[1] | (i == 4);
            keyboard_irq_mask = !i[1];
            lvi_trip = (i == 4);
            n = 0;
            while (in_stop === 1'b1 && n < 20)
            begin
                tick(1);
                n++;
            end
            if (i == 4)
            begin
                cmp("imask_set", 1, imask_set);
                cmp("lvi_reset_out", 1, lvi_reset_out);
                cmp("lvi_active", 1, lvi_active);
            end
            n = 0;
            while (cpu_clk_en !== 1'b1 && n < 300)
            begin
                tick(1);
                n++;
            end
            {pin_irq_mask, keyboard_irq_mask, pin_go, kbd_go, lvi_trip} = 5'h18;
            if (i < 4)
                cmpn("recovery", rec_exp(i[0]), n);
            cmp("adc_run", 1, adc_run);
            tick(4);
        end
        end_of_test;
    end
endmodule
